/* core/acsq_pkg.sv */
package acsq_pkg;

  typedef enum logic [1:0] {
    ST_PWRDN = 2'h0,
    ST_IDLE = 2'h1,
    ST_SETTLE = 2'h2,
    ST_CONV = 2'h3
  } acsq_state_t;

  localparam int CHAN_NUM = 29;
  localparam int CHAN_W = 5;
  localparam int CNT_W = 14;

  // channel index layout, lowest index is highest priority
  localparam logic [4:0] SE_BASE = 5'h08;
  localparam logic [4:0] INT_BASE = 5'h18;
  localparam logic [4:0] COMMON_INPUT = 5'h10;
  localparam logic [4:0] INTERNAL_INPUT = 5'h1F;

  localparam logic [1:0] RATE_11 = 2'h3;
  localparam logic [1:0] RATE_10 = 2'h2;
  localparam logic [1:0] RATE_01 = 2'h1;

  // initial delay in clock cycles, fixed channel from standby
  localparam logic [13:0] INIT_R11 = 14'h0322;
  localparam logic [13:0] INIT_R10 = 14'h04A2;
  localparam logic [13:0] INIT_R01 = 14'h0AA2;
  localparam logic [13:0] AUTO_ADJ = 14'h005E;
  localparam logic [13:0] SLEEP_ADJ = 14'h0040;
  localparam logic [13:0] LATE_WIN = 14'h0008;
  localparam logic [13:0] CNT_DONE = 14'h0001;

  // serial command decode
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [2:0] CMD_WRITE = 3'h3;
  localparam logic [2:0] CMD_PULSE = 3'h4;
  localparam int CMD_MUL_BIT = 4;
  localparam logic [3:0] GPIO_ADDR = 4'h7;

endpackage : acsq_pkg

/* core/acsq_sync.sv */
`timescale 1ns/1ps
module acsq_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // levels
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      syncOut <= '0;
    end else begin
      meta_reg <= asyncIn;
      syncOut <= meta_reg;
    end
  end

endmodule : acsq_sync

/* core/acsq_next_chan.sv */
`timescale 1ns/1ps
module acsq_next_chan #(
  parameter int N = 29,
  parameter int W = 5
) (
  // enabled channels and pointer
  input wire logic [N-1:0] enables,
  input wire logic [W-1:0] current,
  // picks
  output logic [W-1:0] nextChan,
  output logic [W-1:0] firstChan
);

  logic hasLater;

  // descending loop leaves the lowest qualifying index
  always_comb begin
    nextChan = '0;
    firstChan = '0;
    hasLater = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (enables[i]) begin
        firstChan = W'(i);
        if (i > int'(current)) begin
          nextChan = W'(i);
          hasLater = 1'b1;
        end
      end
    end
    if (!hasLater) begin
      nextChan = firstChan;
    end
  end

endmodule : acsq_next_chan

/* core/acsq_sequencer.sv */
`timescale 1ns/1ps
module acsq_sequencer
  import acsq_pkg::*;
#(
  parameter int INIT_DELAY_R00 = 8866,
  parameter int CONV_CYC_R11 = 256,
  parameter int CONV_CYC_R10 = 512,
  parameter int CONV_CYC_R01 = 1024,
  parameter int CONV_CYC_R00 = 4096
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // pins
  input wire logic startPin,
  input wire logic serialClk,
  input wire logic chipSelN,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn,
  output logic resultReadyN,
  output logic [7:0] portPinData,
  // configuration
  input wire logic powerDown,
  input wire logic scanModeSelect,
  input wire logic idleDepthSelect,
  input wire logic [1:0] rateSelect,
  input wire logic [7:0] diffPairSelect,
  input wire logic [7:0] singleEndedLowSelect,
  input wire logic [7:0] singleEndedHighSelect,
  input wire logic [4:0] internalReadingSelect,
  input wire logic [7:0] fixedChannelSelect,
  // status
  output acsq_pkg::acsq_state_t convState,
  output logic idleSleep,
  output logic [4:0] scanChannel,
  output logic [4:0] muxPos,
  output logic [4:0] muxNeg
);
  import acsq_pkg::*;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////
  logic startS, sclkS, csNS, csActive, dinS;
  logic sclkPrev_reg;
  logic [2:0] bitCnt_reg;
  logic [7:0] shift_reg;
  logic firstByte_reg, writeOn_reg, mul_reg;
  logic [3:0] addr_reg;
  logic selected, sclkRise, sclkFall, byteDone;
  logic pulseCmd, regWrite, readClear;
  logic [7:0] portPin_reg;
  logic outEn_reg;

  acsq_sync #(.W(4)) pinSync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .asyncIn({startPin, serialClk, !chipSelN, serialIn}),
    .syncOut({startS, sclkS, csActive, dinS})
  );

  // select level is synced so its reset value matches an idle, deselected pin
  assign csNS = !csActive;

  acsq_state_t state_reg;

  // serial port sleeps with the rest of the device in power-down
  assign selected = !csNS && state_reg != ST_PWRDN;
  assign sclkRise = sclkS && !sclkPrev_reg;
  assign sclkFall = !sclkS && sclkPrev_reg;
  assign byteDone = selected && sclkFall && bitCnt_reg == BYTE_LAST;
  assign pulseCmd = byteDone && firstByte_reg
    && shift_reg[7:5] == CMD_PULSE;
  assign regWrite = byteDone && !firstByte_reg && writeOn_reg;
  // any transfer opening counts as a read start; the op is not known yet
  assign readClear = selected && sclkFall && firstByte_reg
    && bitCnt_reg == 3'h0;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclkPrev_reg <= 1'b0;
    end else begin
      sclkPrev_reg <= sclkS;
    end
  end

  // deselect drops every partial byte and command in flight
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bitCnt_reg <= 3'h0;
      shift_reg <= 8'h00;
    end else if (!selected) begin
      bitCnt_reg <= 3'h0;
      shift_reg <= 8'h00;
    end else begin
      if (sclkRise) begin
        shift_reg <= {shift_reg[6:0], dinS};
      end
      if (sclkFall) begin
        bitCnt_reg <= bitCnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      firstByte_reg <= 1'b1;
      writeOn_reg <= 1'b0;
      mul_reg <= 1'b0;
      addr_reg <= 4'h0;
    end else if (!selected) begin
      firstByte_reg <= 1'b1;
      writeOn_reg <= 1'b0;
    end else if (byteDone) begin
      if (firstByte_reg) begin
        firstByte_reg <= 1'b0;
        writeOn_reg <= shift_reg[7:5] == CMD_WRITE;
        mul_reg <= shift_reg[CMD_MUL_BIT];
        addr_reg <= shift_reg[3:0];
      end else if (writeOn_reg) begin
        if (mul_reg) begin
          addr_reg <= addr_reg + 4'h1;
        end else begin
          writeOn_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      portPin_reg <= 8'h00;
    end else if (regWrite && addr_reg == GPIO_ADDR) begin
      portPin_reg <= shift_reg;
    end
  end

  // readout itself lives elsewhere; only the enable is owned here
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      outEn_reg <= 1'b0;
    end else begin
      outEn_reg <= selected;
    end
  end

  assign serialOutEn = outEn_reg;
  assign serialOut = 1'b0;
  assign portPinData = portPin_reg;

  ////////////////////////////////////////////////////////////////////////////
  logic [13:0] cnt_reg, initDly, period, base;
  logic cont_reg, step_reg, resultEvt, autoMode;
  logic [CHAN_NUM-1:0] enables;
  logic [4:0] ptr_reg, nextChan, firstChan;

  assign autoMode = scanModeSelect;
  assign enables = {internalReadingSelect, singleEndedHighSelect,
    singleEndedLowSelect, diffPairSelect};
  assign resultEvt = (state_reg == ST_SETTLE || state_reg == ST_CONV)
    && cnt_reg == CNT_DONE;

  acsq_next_chan #(.N(CHAN_NUM), .W(CHAN_W)) picker (
    .enables(enables),
    .current(ptr_reg),
    .nextChan(nextChan),
    .firstChan(firstChan)
  );

  always_comb begin
    case (rateSelect)
      RATE_11: begin
        base = INIT_R11;
        period = 14'(CONV_CYC_R11);
      end
      RATE_10: begin
        base = INIT_R10;
        period = 14'(CONV_CYC_R10);
      end
      RATE_01: begin
        base = INIT_R01;
        period = 14'(CONV_CYC_R01);
      end
      default: begin
        base = 14'(INIT_DELAY_R00);
        period = 14'(CONV_CYC_R00);
      end
    endcase
    initDly = base - (autoMode ? AUTO_ADJ : 14'h0000)
      + (idleDepthSelect ? SLEEP_ADJ : 14'h0000);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 14'h0000;
      cont_reg <= 1'b0;
      step_reg <= 1'b0;
    end else if (powerDown) begin
      state_reg <= ST_PWRDN;
      cont_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_PWRDN: begin
          state_reg <= ST_IDLE;
        end
        ST_IDLE: begin
          if (startS) begin
            state_reg <= ST_SETTLE;
            cnt_reg <= initDly;
            cont_reg <= 1'b1;
            step_reg <= 1'b0;
          end else if (pulseCmd) begin
            state_reg <= ST_SETTLE;
            cnt_reg <= initDly;
            cont_reg <= 1'b0;
            step_reg <= 1'b1;
          end
        end
        ST_SETTLE, ST_CONV: begin
          // the run/stop choice is frozen 7 cycles before the result
          if (cnt_reg == LATE_WIN) begin
            cont_reg <= startS && !step_reg;
          end
          if (resultEvt) begin
            if (cont_reg) begin
              state_reg <= ST_CONV;
              cnt_reg <= period;
            end else begin
              state_reg <= ST_IDLE;
            end
          end else begin
            cnt_reg <= cnt_reg - 14'h0001;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // a write resets the scan even mid-run; fixed mode leaves it alone
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_reg <= 5'h00;
    end else if (autoMode) begin
      if (regWrite) begin
        ptr_reg <= firstChan;
      end else if (resultEvt) begin
        ptr_reg <= nextChan;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [4:0] chanSel, posNext, negNext;
  logic [4:0] pos_reg, neg_reg, scan_reg;
  logic convStart, sleep_reg;

  assign convStart = (state_reg == ST_IDLE && !powerDown
    && (startS || pulseCmd)) || (resultEvt && cont_reg && !powerDown);
  assign chanSel = resultEvt ? nextChan : ptr_reg;

  always_comb begin
    if (!autoMode) begin
      posNext = {1'b0, fixedChannelSelect[7:4]};
      negNext = {1'b0, fixedChannelSelect[3:0]};
    end else if (chanSel < SE_BASE) begin
      posNext = {chanSel[3:0], 1'b0};
      negNext = {chanSel[3:0], 1'b1};
    end else if (chanSel < INT_BASE) begin
      posNext = chanSel - SE_BASE;
      negNext = COMMON_INPUT;
    end else begin
      posNext = INTERNAL_INPUT;
      negNext = INTERNAL_INPUT;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pos_reg <= 5'h00;
      neg_reg <= 5'h00;
      scan_reg <= 5'h00;
    end else if (convStart) begin
      pos_reg <= posNext;
      neg_reg <= negNext;
      scan_reg <= autoMode ? chanSel : 5'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sleep_reg <= 1'b0;
    end else begin
      sleep_reg <= state_reg == ST_IDLE && idleDepthSelect;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic rdyN_reg, blip_reg;

  // a new result beats a read edge arriving in the same cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdyN_reg <= 1'b1;
      blip_reg <= 1'b0;
    end else if (state_reg == ST_PWRDN) begin
      rdyN_reg <= 1'b1;
      blip_reg <= 1'b0;
    end else if (resultEvt) begin
      if (!rdyN_reg) begin
        rdyN_reg <= 1'b1;
        blip_reg <= 1'b1;
      end else begin
        rdyN_reg <= 1'b0;
      end
    end else if (blip_reg) begin
      rdyN_reg <= 1'b0;
      blip_reg <= 1'b0;
    end else if (readClear) begin
      rdyN_reg <= 1'b1;
    end
  end

  assign resultReadyN = rdyN_reg;
  assign convState = state_reg;
  assign idleSleep = sleep_reg;
  assign scanChannel = scan_reg;
  assign muxPos = pos_reg;
  assign muxNeg = neg_reg;

  ////////////////////////////////////////////////////////////////////////////
  out_tristate_a: assert property (
    csNS |=> !serialOutEn) else $error("output driven while deselected");
  pulse_once_a: assert property (
    state_reg == ST_IDLE && pulseCmd && !startS && !powerDown
    |=> state_reg == ST_SETTLE && !cont_reg)
    else $error("pulse convert did not start one conversion");
  init_delay_a: assert property (
    state_reg == ST_IDLE && startS && !powerDown
    |=> cnt_reg == $past(initDly)) else $error("wrong initial delay");
  stop_idle_a: assert property (
    resultEvt && !cont_reg && !powerDown |=> state_reg == ST_IDLE)
    else $error("did not idle after last conversion");
  run_on_a: assert property (
    resultEvt && cont_reg && !powerDown
    |=> state_reg == ST_CONV && cnt_reg == $past(period))
    else $error("continuous run broke");
  ready_blip_a: assert property (
    resultEvt && !rdyN_reg && state_reg != ST_PWRDN && !powerDown
    |=> resultReadyN ##1 !resultReadyN) else $error("missing ready blip");
  ptr_reset_a: assert property (
    autoMode && regWrite |=> ptr_reg == $past(firstChan))
    else $error("write did not reset pointer");
  fixed_hold_a: assert property (
    !autoMode |=> $stable(ptr_reg)) else $error("pointer moved in fixed");
  ptr_adv_a: assert property (
    autoMode && resultEvt && !regWrite |=> ptr_reg == $past(nextChan))
    else $error("pointer did not advance");
  gpio_upd_a: assert property (
    regWrite && addr_reg == GPIO_ADDR |=> portPinData == $past(shift_reg))
    else $error("port pin not updated");
  power_down_a: assert property (
    powerDown |=> state_reg == ST_PWRDN ##1 resultReadyN)
    else $error("power-down not entered");

  run_cover_c: cover property (resultEvt && cont_reg ##1 state_reg == ST_CONV);
  pulse_cover_c: cover property (pulseCmd && state_reg == ST_IDLE);
  blip_cover_c: cover property (blip_reg);
  write_cover_c: cover property (regWrite && autoMode);

endmodule : acsq_sequencer

/* sim/acsq_host_model.sv */
`timescale 1ns/1ps
module acsq_host_model (
  // clock
  input wire logic ref_clk,
  // pins
  output logic startLvl,
  output logic serialClk,
  output logic chipSelN,
  output logic serialIn
);
  initial begin
    startLvl = 1'b0;
    serialClk = 1'b0;
    chipSelN = 1'b1;
    serialIn = 1'b0;
  end

  task automatic setStart(input logic v);
    @(posedge ref_clk);
    #2;
    startLvl = v;
  endtask : setStart

  task automatic select();
    @(posedge ref_clk);
    #2;
    chipSelN = 1'b0;
    #300;
  endtask : select

  // released data line shows no stale value
  task automatic deselect();
    #300;
    chipSelN = 1'b1;
    serialIn = ~serialIn;
  endtask : deselect

  // msb first, 400 ns link period; clock idles low between bits
  task automatic shiftBits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      serialIn = b[i];
      #100 serialClk = 1'b1;
      #200 serialClk = 1'b0;
      #100;
    end
  endtask : shiftBits

  // whole bytes only, chip select low throughout
  task automatic transfer(input logic [15:0] w, input int nb);
    select();
    shiftBits(w[15:8], 8);
    if (nb > 1) begin
      shiftBits(w[7:0], 8);
    end
    deselect();
  endtask : transfer
endmodule : acsq_host_model

/* sim/acsq_sequencer_bench.sv */
`timescale 1ns/1ps
module acsq_sequencer_bench;
  import acsq_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic powerDown = 1'b0;
  logic scanModeSelect = 1'b1;
  logic idleDepthSelect = 1'b0;
  logic [1:0] rateSelect = 2'h3;
  logic [7:0] diffPairSelect = 8'h05;
  logic [7:0] singleEndedLowSelect = 8'h02;
  logic [7:0] singleEndedHighSelect = 8'h00;
  logic [4:0] internalReadingSelect = 5'h00;
  logic [7:0] fixedChannelSelect = 8'h32;
  logic loopEn = 1'b0;
  logic startLvl, serialClk, chipSelN, serialIn;
  logic serialOut, serialOutEn, resultReadyN, idleSleep;
  logic [7:0] portPinData;
  logic [4:0] scanChannel, muxPos, muxNeg;
  acsq_state_t convState;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  int n, t0;
  // port pin looped back onto the start pin
  wire logic startPin = startLvl | (loopEn & portPinData[0]);

  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  acsq_host_model host (
    .ref_clk(ref_clk),
    .startLvl(startLvl),
    .serialClk(serialClk),
    .chipSelN(chipSelN),
    .serialIn(serialIn)
  );

  acsq_sequencer #(
    .INIT_DELAY_R00(200),
    .CONV_CYC_R11(32),
    .CONV_CYC_R10(32),
    .CONV_CYC_R01(32),
    .CONV_CYC_R00(32)
  ) uut (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .startPin(startPin),
    .serialClk(serialClk),
    .chipSelN(chipSelN),
    .serialIn(serialIn),
    .serialOut(serialOut),
    .serialOutEn(serialOutEn),
    .resultReadyN(resultReadyN),
    .portPinData(portPinData),
    .powerDown(powerDown),
    .scanModeSelect(scanModeSelect),
    .idleDepthSelect(idleDepthSelect),
    .rateSelect(rateSelect),
    .diffPairSelect(diffPairSelect),
    .singleEndedLowSelect(singleEndedLowSelect),
    .singleEndedHighSelect(singleEndedHighSelect),
    .internalReadingSelect(internalReadingSelect),
    .fixedChannelSelect(fixedChannelSelect),
    .convState(convState),
    .idleSleep(idleSleep),
    .scanChannel(scanChannel),
    .muxPos(muxPos),
    .muxNeg(muxNeg)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #2;
  endtask : tick

  // what: 0..3 a state, 4 ready low, 5 ready high
  task automatic waitUntil(input int what, input int lim, output int k);
    for (k = 1; k <= lim; k++) begin
      @(posedge ref_clk);
      #1;
      if ((what < 4) ? (convState === acsq_state_t'(what)) :
          (resultReadyN === (what == 5))) begin
        return;
      end
    end
    mismatches++;
    $display("unexpected at %0t: wait %0h limit %0h", $time, what, lim);
    results();
  endtask : waitUntil

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(10);
    rst_b = 1'b1;
    tick(1);
    check(convState, ST_IDLE);
    check(resultReadyN, 1'b1);
    check(portPinData, 8'h00);
    check(serialOutEn, 1'b0);
    $display("test reset done");

    // auto-scan over diff 0, diff 2, single-ended 1
    host.setStart(1'b1);
    waitUntil(2, 10, n);
    check(scanChannel, 5'h00);
    check({muxPos, muxNeg}, {5'h00, 5'h01});
    waitUntil(4, 800, n);
    check(16'(n), 16'h02C4);
    tick(2);
    check(convState, ST_CONV);
    check({muxPos, muxNeg}, {5'h04, 5'h05});
    waitUntil(5, 40, n);
    t0 = cyc;
    waitUntil(4, 2, n);
    tick(2);
    check(scanChannel, 5'h09);
    check({muxPos, muxNeg}, {5'h01, 5'h10});
    waitUntil(5, 40, n);
    check(16'(cyc - t0), 16'h0020);
    waitUntil(4, 2, n);
    tick(2);
    check(scanChannel, 5'h00);
    host.setStart(1'b0);
    waitUntil(1, 40, n);
    check(resultReadyN, 1'b1);
    tick(1);
    check(resultReadyN, 1'b0);
    $display("test auto-scan done");

    // write resets pointer, short start converts one channel
    host.transfer(16'h6700, 2);
    host.setStart(1'b1);
    waitUntil(2, 10, n);
    check(scanChannel, 5'h00);
    host.setStart(1'b0);
    waitUntil(4, 800, n);
    tick(2);
    check(convState, ST_IDLE);
    host.setStart(1'b1);
    waitUntil(2, 10, n);
    check(scanChannel, 5'h02);
    host.setStart(1'b0);
    waitUntil(1, 800, n);
    $display("test pointer done");

    // fixed channel, single step from sleep
    tick(1);
    scanModeSelect = 1'b0;
    idleDepthSelect = 1'b1;
    rateSelect = 2'h1;
    fixedChannelSelect = 8'hA5;
    tick(3);
    check(idleSleep, 1'b1);
    host.select();
    host.shiftBits(8'h80, 8);
    waitUntil(2, 10, n);
    t0 = cyc;
    check({muxPos, muxNeg}, {5'h0A, 5'h05});
    host.deselect();
    waitUntil(4, 3000, n);
    check(16'(cyc - t0), 16'h0AE2);
    tick(2);
    check(convState, ST_IDLE);
    host.transfer(16'h3000, 1);
    check(resultReadyN, 1'b1);
    $display("test pulse done");

    // port pin drives start through the loop
    idleDepthSelect = 1'b0;
    rateSelect = 2'h0;
    loopEn = 1'b1;
    host.transfer(16'h6701, 2);
    check(portPinData, 8'h01);
    waitUntil(4, 900, n);
    host.transfer(16'h6700, 2);
    check(portPinData, 8'h00);
    waitUntil(1, 100, n);
    $display("test loop done");

    // half a pulse command, deselect, other half
    host.select();
    tick(3);
    check({serialOutEn, serialOut}, 2'h2);
    host.shiftBits(8'h80, 4);
    host.deselect();
    tick(3);
    check(serialOutEn, 1'b0);
    host.select();
    host.shiftBits(8'h00, 4);
    tick(10);
    check(convState, ST_IDLE);
    $display("test deselect done");

    // power-down ignores the serial port
    tick(1);
    powerDown = 1'b1;
    tick(2);
    check(convState, ST_PWRDN);
    check(serialOutEn, 1'b0);
    check(resultReadyN, 1'b1);
    host.shiftBits(8'h80, 8);
    host.deselect();
    tick(1);
    powerDown = 1'b0;
    tick(3);
    check(convState, ST_IDLE);
    $display("test power-down done");

    // upper single-ended input and an internal reading at rate 10
    scanModeSelect = 1'b1;
    rateSelect = 2'h2;
    diffPairSelect = 8'h00;
    singleEndedLowSelect = 8'h00;
    singleEndedHighSelect = 8'h80;
    internalReadingSelect = 5'h02;
    host.transfer(16'h6100, 2);
    host.setStart(1'b1);
    waitUntil(2, 10, n);
    check(scanChannel, 5'h17);
    check({muxPos, muxNeg}, {5'h0F, 5'h10});
    waitUntil(4, 1200, n);
    check(16'(n), 16'h0444);
    tick(2);
    check(scanChannel, 5'h19);
    check({muxPos, muxNeg}, {5'h1F, 5'h1F});
    host.setStart(1'b0);
    waitUntil(1, 40, n);
    $display("test internal done");
    results();
  end
endmodule : acsq_sequencer_bench
